/* i2c_tx_flush_ctrl.sv */
// i2c target tx fifo flush, auto-flush lockout and preload control
// assumes: one clock, synchronous single-cycle strobes from the cpu port,
// and one-cycle event pulses from the target link logic
`timescale 1ns/1ns
`include "i2c_txflush_cfg.svh"
module i2c_tx_flush_ctrl #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data_ff,
  output logic irq_ff,
  input wire logic nack_end,
  input wire logic rd_match,
  input wire logic wr_match,
  input wire logic gc_match,
  input wire logic hw_ready_set,
  input wire logic tx_pop,
  output logic [WIDTH-1:0] tx_byte,
  output logic [3:0] tx_level,
  output logic lockout_ff,
  output logic preload_mode_ff,
  output logic preload_rdy_ff,
  output logic addr_nack_ff
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = 4;

  // the level field is four bits and the pointers wrap by width
  if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be 2, 4 or 8");
  end
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("WIDTH must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////
  // register decode
  logic wr_c0, wr_c1, wr_dat, wr_stat, wr_mask;
  logic rd_c0, rd_c1, rd_stat, rd_mask;
  assign wr_c0 = wr_en && (addr == `REG_TXC0);
  assign wr_c1 = wr_en && (addr == `REG_TXC1);
  assign wr_dat = wr_en && (addr == `REG_TXDATA);
  assign wr_stat = wr_en && (addr == `REG_EVT_STAT);
  assign wr_mask = wr_en && (addr == `REG_EVT_MASK);
  assign rd_c0 = rd_en && (addr == `REG_TXC0);
  assign rd_c1 = rd_en && (addr == `REG_TXC1);
  assign rd_stat = rd_en && (addr == `REG_EVT_STAT);
  assign rd_mask = rd_en && (addr == `REG_EVT_MASK);

  ////////////////////////////////////////////////////////////////////
  // control bits of the first tx control register
  logic nack_autoclear_off_ff, read_match_autoclear_off_ff;
  logic write_match_autoclear_off_ff, general_call_autoclear_off_ff;
  logic ready_sw_mode_ff;
  logic preload_entry;
  logic nxt_nack_off, nxt_rd_off, nxt_wr_off, nxt_gc_off;
  logic nxt_rdy_sw, nxt_preload, nxt_rdy, rdy_set;

  // entry presets win over the written values only in the entry write;
  // afterwards software owns the bits again
  assign preload_entry = wr_c0 && wdata[`C0_PRELOAD] && !preload_mode_ff;
  assign nxt_nack_off = preload_entry ? 1'b0 : // R04
    (wr_c0 ? wdata[`C0_NACK_OFF] : nack_autoclear_off_ff); // R03
  assign nxt_rd_off = preload_entry ? 1'b1 : // R08
    (wr_c0 ? wdata[`C0_RD_OFF] : read_match_autoclear_off_ff); // R05
  assign nxt_wr_off = preload_entry ? 1'b1 : // R08
    (wr_c0 ? wdata[`C0_WR_OFF] : write_match_autoclear_off_ff); // R06
  assign nxt_gc_off = preload_entry ? 1'b1 : // R08
    (wr_c0 ? wdata[`C0_GC_OFF] : general_call_autoclear_off_ff); // R07
  assign nxt_rdy_sw = wr_c0 ? wdata[`C0_RDY_SW] : ready_sw_mode_ff;
  assign nxt_preload = wr_c0 ? wdata[`C0_PRELOAD] : preload_mode_ff;

  // ready flag: software writes a one, or the link logic sets it
  assign rdy_set = ready_sw_mode_ff ? (wr_c1 && wdata[`C1_RDY]) : hw_ready_set; // R09
  assign nxt_rdy = !nxt_preload ? 1'b1 : // R11
    (preload_entry ? 1'b0 : (preload_rdy_ff | rdy_set)); // R11

  // bit 6 has no flop at all, so writes cannot reach it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nack_autoclear_off_ff <= `C0_BIT_RESET;
      read_match_autoclear_off_ff <= `C0_BIT_RESET;
      write_match_autoclear_off_ff <= `C0_BIT_RESET;
      general_call_autoclear_off_ff <= `C0_BIT_RESET;
      ready_sw_mode_ff <= `C0_BIT_RESET;
      preload_mode_ff <= `C0_BIT_RESET;
      preload_rdy_ff <= `C1_RDY_RESET;
      addr_nack_ff <= 1'b0;
    end else if (ce) begin
      nack_autoclear_off_ff <= nxt_nack_off;
      read_match_autoclear_off_ff <= nxt_rd_off;
      write_match_autoclear_off_ff <= nxt_wr_off;
      general_call_autoclear_off_ff <= nxt_gc_off;
      ready_sw_mode_ff <= nxt_rdy_sw;
      preload_mode_ff <= nxt_preload;
      preload_rdy_ff <= nxt_rdy;
      addr_nack_ff <= nxt_preload && !nxt_rdy; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////
  // automatic flush triggers and software flush
  logic addr_trig, nack_trig, lock_set, sw_flush, flush_start;
  logic seq_clear, seq_busy, seq_done;

  // in preload mode an address match leaves the fifo alone so it can be
  // filled ahead of the transfer; a nack at the end still flushes
  assign addr_trig = !preload_mode_ff && ( // R10
    (rd_match && !read_match_autoclear_off_ff) || // R05
    (wr_match && !write_match_autoclear_off_ff) || // R06
    (gc_match && !general_call_autoclear_off_ff)); // R07
  assign nack_trig = nack_end && !nack_autoclear_off_ff; // R03
  assign lock_set = addr_trig || nack_trig;
  assign sw_flush = wr_c0 && wdata[`C0_FLUSH]; // R01
  assign flush_start = sw_flush || lock_set;

  flush_sequencer u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(flush_start),
    .clear(seq_clear),
    .busy(seq_busy),
    .done(seq_done)
  );

  ////////////////////////////////////////////////////////////////////
  // fifo: pushes are refused during lockout and while a flush runs
  logic push;
  assign push = wr_dat && !lockout_ff && !seq_busy; // R10

  tx_fifo_mem #(
    .W(WIDTH),
    .D(DEPTH),
    .AW(AW),
    .LW(LW)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .clear(seq_clear),
    .push(push),
    .wdata(wdata[WIDTH-1:0]),
    .pop(tx_pop),
    .head_ff(tx_byte),
    .count_ff(tx_level)
  );

  ////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear; a set in the clear cycle wins
  logic [`EVT_W-1:0] evt_ff, evt_set, evt_clr, nxt_evt;
  logic [`EVT_W-1:0] evt_mask_ff, nxt_mask;
  assign evt_set[`EVT_LOCKOUT] = lock_set; // R10
  assign evt_set[`EVT_FLUSHED] = seq_done;
  assign evt_set[`EVT_NACK] = nack_trig;
  assign evt_clr = wr_stat ? wdata[`EVT_W-1:0] : '0;
  assign nxt_mask = wr_mask ? wdata[`EVT_W-1:0] : evt_mask_ff;

  for (genvar i = 0; i < `EVT_W; i++) begin : g_evt
    assign nxt_evt[i] = evt_set[i] | (evt_ff[i] & ~evt_clr[i]);
  end

  // the lockout flag is the sticky lockout event itself
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_ff <= `EVT_RESET;
      evt_mask_ff <= `EVT_RESET;
      lockout_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      evt_ff <= nxt_evt;
      evt_mask_ff <= nxt_mask;
      lockout_ff <= nxt_evt[`EVT_LOCKOUT]; // R10
      irq_ff <= |(nxt_evt & nxt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data; unmapped addresses and data reads return zero
  logic [31:0] c0_word, c1_word, rd_mux;
  assign c0_word = {24'h0,
    seq_busy | lockout_ff, // R01 R02
    1'b0, // R12
    nack_autoclear_off_ff,
    read_match_autoclear_off_ff,
    write_match_autoclear_off_ff,
    general_call_autoclear_off_ff,
    ready_sw_mode_ff, // R09
    preload_mode_ff};
  assign c1_word = {20'h0, tx_level, 7'h0, preload_rdy_ff};
  assign rd_mux = rd_c0 ? c0_word :
    rd_c1 ? c1_word :
    rd_stat ? {29'h0, evt_ff} :
    rd_mask ? {29'h0, evt_mask_ff} : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_ff <= 32'h0;
    end else if (ce) begin
      rd_data_ff <= rd_en ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_LOCK_SHOWS_FLUSH: assert property (@(posedge clk) disable iff (sys_rst) // R02
    ce && rd_c0 && lockout_ff |=> rd_data_ff[`C0_FLUSH])
    else $error("flush bit low while locked out");

  AST_NACK_LOCKS: assert property (@(posedge clk) disable iff (sys_rst) // R03
    ce && nack_end && !nack_autoclear_off_ff |=> lockout_ff ##1 (!ce || seq_busy))
    else $error("nack did not flush and lock");

  AST_ENTRY_NACK_ON: assert property (@(posedge clk) disable iff (sys_rst) // R04
    ce && preload_entry |=> !nack_autoclear_off_ff && preload_mode_ff)
    else $error("preload entry left nack flush off");

  AST_RD_MATCH: assert property (@(posedge clk) disable iff (sys_rst) // R05
    ce && rd_match && !read_match_autoclear_off_ff && !preload_mode_ff |=> lockout_ff)
    else $error("read match did not lock");

  AST_WR_MATCH: assert property (@(posedge clk) disable iff (sys_rst) // R06
    ce && wr_match && !write_match_autoclear_off_ff && !preload_mode_ff |=> lockout_ff)
    else $error("write match did not lock");

  AST_GC_MATCH: assert property (@(posedge clk) disable iff (sys_rst) // R07
    ce && gc_match && !general_call_autoclear_off_ff && !preload_mode_ff
    |=> lockout_ff)
    else $error("general call did not lock");

  AST_ENTRY_OFF_SET: assert property (@(posedge clk) disable iff (sys_rst) // R08
    ce && preload_entry |=> read_match_autoclear_off_ff &&
    write_match_autoclear_off_ff && general_call_autoclear_off_ff)
    else $error("preload entry did not set disables");

  AST_HW_READY: assert property (@(posedge clk) disable iff (sys_rst) // R09
    ce && preload_mode_ff && !ready_sw_mode_ff && hw_ready_set && !wr_c0
    |=> preload_rdy_ff)
    else $error("hardware ready set ignored");

  AST_PRELOAD_NO_LOCK: assert property (@(posedge clk) disable iff (sys_rst) // R10
    ce && preload_mode_ff && !nack_trig && !lockout_ff |=> !lockout_ff)
    else $error("lockout in preload mode");

  AST_NACK_WHILE_UNREADY: assert property (@(posedge clk) disable iff (sys_rst) // R11
    addr_nack_ff == (preload_mode_ff && !preload_rdy_ff))
    else $error("address answer disagrees with ready flag");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R12
    ce && rd_c0 |=> !rd_data_ff[`C0_RSVD])
    else $error("reserved bit read nonzero");
endmodule : i2c_tx_flush_ctrl

/* i2c_txflush_cfg.svh */
// i2c tx flush control: register offsets, field positions, reset values, counts
// assumes: included by bare name from the register block, the sequencer and the bench, not the fifo
// Function
// R01: flush bit write empties fifo, self-clears
// R02: lockout set forces flush bit to one
// R03: bit 5 disables nack auto flush
// R04: preload entry clears bit 5 once
// R05: bit 4 disables read-match auto flush
// R06: bit 3 disables write-match auto flush
// R07: bit 2 disables general-call auto flush
// R08: preload entry sets bits 4..2 once
// R09: bit 1 hands ready flag to software
// R10: address match flushes and locks unless preload
// R11: preload ready low means address nack
// R12: bit 6 reads zero, ignores writes
`ifndef I2C_TXFLUSH_CFG_SVH
`define I2C_TXFLUSH_CFG_SVH
`define REG_TXC0 8'h24
`define REG_TXC1 8'h28
`define REG_TXDATA 8'h2c
`define REG_EVT_STAT 8'h40
`define REG_EVT_MASK 8'h44
`define C0_FLUSH 7
`define C0_RSVD 6
`define C0_NACK_OFF 5
`define C0_RD_OFF 4
`define C0_WR_OFF 3
`define C0_GC_OFF 2
`define C0_RDY_SW 1
`define C0_PRELOAD 0
`define C1_RDY 0
`define C1_LVL_LSB 8
`define EVT_LOCKOUT 0
`define EVT_FLUSHED 1
`define EVT_NACK 2
`define EVT_W 3
`define C0_BIT_RESET 1'b0
`define C1_RDY_RESET 1'b1
`define EVT_RESET 3'h0
`define FLUSH_CYCLES 2'h1
`endif

/* i2c_txflush_pkg.sv */
// i2c tx flush control: shared types
// assumes: nothing beyond a sv compiler
package i2c_txflush_pkg;
  typedef enum logic [1:0] {FL_IDLE, FL_CLEAR, FL_DONE} flush_state_t;
endpackage : i2c_txflush_pkg

/* tx_fifo_mem.sv */
// tx fifo storage with registered head byte and level
// assumes: depth is a power of two, checked by the parent
`timescale 1ns/1ns
module tx_fifo_mem #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int AW = 3,
  parameter int LW = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] head_ff,
  output logic [LW-1:0] count_ff
);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] rptr_ff, wptr_ff, nxt_rptr;
  logic do_push, do_pop;
  logic [LW-1:0] nxt_count;

  // clear beats push and pop, so a flush never leaves a stray byte
  assign do_push = push && (count_ff != LW'(D)) && !clear;
  assign do_pop = pop && (count_ff != '0) && !clear;
  assign nxt_rptr = clear ? '0 : rptr_ff + AW'(do_pop);
  assign nxt_count = clear ? '0 : count_ff + LW'(do_push) - LW'(do_pop);

  ////////////////////////////////////////////////////////////////////
  // pointers, level and head; head bypasses a byte written into its slot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rptr_ff <= '0;
      wptr_ff <= '0;
      count_ff <= '0;
      head_ff <= '0;
    end else if (ce) begin
      rptr_ff <= nxt_rptr;
      wptr_ff <= clear ? '0 : wptr_ff + AW'(do_push);
      count_ff <= nxt_count;
      // an empty fifo shows zero, never a stale or unwritten slot
      head_ff <= (nxt_count == '0) ? '0 :
        ((do_push && wptr_ff == nxt_rptr) ? wdata : mem_ff[nxt_rptr]);
    end
  end

  // storage itself needs no reset: level says what is valid
  always_ff @(posedge clk) begin
    if (ce && do_push) begin
      mem_ff[wptr_ff] <= wdata;
    end
  end

  AST_CLEAR_EMPTIES: assert property (@(posedge clk) disable iff (sys_rst) // R01
    ce && clear |=> count_ff == '0)
    else $error("fifo not empty after clear");
endmodule : tx_fifo_mem

/* flush_sequencer.sv */
// flush sequencer: runs one flush and reports busy and done
// assumes: start is a one-cycle request from the register logic
`timescale 1ns/1ns
`include "i2c_txflush_cfg.svh"
module flush_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  output logic clear,
  output logic busy,
  output logic done
);
  i2c_txflush_pkg::flush_state_t state_ff, nxt_state;
  logic [1:0] cnt_ff, nxt_cnt;

  // a request while done restarts at once instead of being dropped
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      i2c_txflush_pkg::FL_IDLE: begin
        if (start) begin
          nxt_state = i2c_txflush_pkg::FL_CLEAR;
          nxt_cnt = `FLUSH_CYCLES;
        end
      end
      i2c_txflush_pkg::FL_CLEAR: begin
        if (cnt_ff <= 2'h1) begin
          nxt_state = i2c_txflush_pkg::FL_DONE;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      i2c_txflush_pkg::FL_DONE: begin
        if (start) begin
          nxt_state = i2c_txflush_pkg::FL_CLEAR;
          nxt_cnt = `FLUSH_CYCLES;
        end else begin
          nxt_state = i2c_txflush_pkg::FL_IDLE;
        end
      end
      default: nxt_state = i2c_txflush_pkg::FL_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= i2c_txflush_pkg::FL_IDLE;
      cnt_ff <= 2'h0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // flush bit reads one from request until done has passed
  assign clear = state_ff == i2c_txflush_pkg::FL_CLEAR; // R01
  assign busy = state_ff != i2c_txflush_pkg::FL_IDLE;
  assign done = state_ff == i2c_txflush_pkg::FL_DONE;

  AST_FLUSH_ENDS: assert property (@(posedge clk) disable iff (sys_rst) // R01
    ce && start && !busy |=> clear ##1 (!ce || done))
    else $error("flush did not complete in time");
endmodule : flush_sequencer

/* tx_link_model.sv */
// partner model: the external controller that addresses this target
// assumes: the bench calls hit(); one clock, pulses last one cycle
`timescale 1ns/1ns
module tx_link_model (
  input wire logic clk,
  input wire logic addr_nack_ff,
  output logic nack_end,
  output logic rd_match,
  output logic wr_match,
  output logic gc_match,
  output logic hw_ready_set,
  output logic tx_pop
);
  int n_acked;
  int n_nacked;
  initial begin
    {nack_end, rd_match, wr_match, gc_match, hw_ready_set, tx_pop} = 6'h00;
    n_acked = 0;
    n_nacked = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one event pulse; k counts from nack_end down the port list
  task automatic hit(input int k);
    @(posedge clk);
    {nack_end, rd_match, wr_match, gc_match, hw_ready_set, tx_pop} <= 6'h20 >> k;
    @(posedge clk);
    {nack_end, rd_match, wr_match, gc_match, hw_ready_set, tx_pop} <= 6'h00;
  endtask : hit
  // an address phase is answered from the nack flag the device shows
  always @(posedge clk) begin
    if (rd_match | wr_match | gc_match) begin
      if (addr_nack_ff) n_nacked++;
      else n_acked++;
    end
  end
endmodule : tx_link_model

/* i2c_tx_flush_ctrl_tb.sv */
// testbench: flush, auto-flush lockout, preload and interrupt checks
// assumes: one clock at 100 MHz; ce dropped once to check the freeze
`timescale 1ns/1ns
`include "i2c_txflush_cfg.svh"
module i2c_tx_flush_ctrl_tb;
  logic clk, sys_rst, ce, wr_en, rd_en, irq_ff, tx_pop, hw_ready_set;
  logic nack_end, rd_match, wr_match, gc_match;
  logic lockout_ff, preload_mode_ff, preload_rdy_ff, addr_nack_ff;
  logic [7:0] addr, tx_byte, b0, b1;
  logic [31:0] wdata, rd_data_ff, w;
  logic [3:0] tx_level;
  int num_errors, n_tests, seed;
  i2c_tx_flush_ctrl u_i2c_tx_flush_ctrl (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_ff(rd_data_ff), .irq_ff(irq_ff), .nack_end(nack_end),
    .rd_match(rd_match), .wr_match(wr_match), .gc_match(gc_match),
    .hw_ready_set(hw_ready_set), .tx_pop(tx_pop), .tx_byte(tx_byte),
    .tx_level(tx_level), .lockout_ff(lockout_ff),
    .preload_mode_ff(preload_mode_ff), .preload_rdy_ff(preload_rdy_ff),
    .addr_nack_ff(addr_nack_ff));
  tx_link_model u_tx_link_model (.clk(clk), .addr_nack_ff(addr_nack_ff),
    .nack_end(nack_end), .rd_match(rd_match), .wr_match(wr_match),
    .gc_match(gc_match), .hw_ready_set(hw_ready_set), .tx_pop(tx_pop));
  ////////////////////////////////////////////////////////////////////////
  // compare, bus cycles and the closing task
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // read data is valid only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("read", rd_data_ff, ex);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // preload entry: nack off cleared, the three address offs set
  function automatic logic [31:0] exp_entry(input logic [31:0] v);
    return (v & 32'h0000_0003) | 32'h0000_001c;
  endfunction : exp_entry
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    #200000;
    num_errors++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, ce, wr_en, rd_en, addr, wdata} = {2'h3, 2'h0, 8'h00, 32'h0};
    {num_errors, n_tests, seed} = {32'h0, 32'h0, 32'he1a5};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`REG_TXC0, 32'h0);
    rd(`REG_TXC1, 32'h1);
    rd(8'h10, 32'h0);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    wr(`REG_TXDATA, {24'h0, b0});
    wr(`REG_TXDATA, {24'h0, b1});
    settle;
    chk("level", tx_level, 32'h2);
    chk("head", tx_byte, b0);
    u_tx_link_model.hit(5);
    settle;
    chk("head", tx_byte, b1);
    // flush with the reserved bit also written; flush bit reads busy
    wr(`REG_TXC0, 32'h0000_00c0);
    rd(`REG_TXC0, 32'h0000_0080);
    settle;
    chk("level", tx_level, 32'h0);
    rd(`REG_TXC0, 32'h0);
    $display("test flush done");
    // each auto-flush trigger, with its off bit clear and then set
    for (int k = 0; k < 4; k++) begin
      for (int off = 0; off < 2; off++) begin
        wr(`REG_TXC0, off ? (32'h20 >> k) : 32'h0);
        wr(`REG_TXDATA, 32'($random(seed)));
        u_tx_link_model.hit(k);
        settle;
        chk("lockout", lockout_ff, 32'(off == 0));
        chk("level", tx_level, 32'(off));
        if (off == 0) begin
          rd(`REG_TXC0, 32'h0000_0080);
          wr(`REG_TXDATA, 32'h0000_00a5);
          settle;
          chk("level", tx_level, 32'h0);
          wr(`REG_EVT_STAT, 32'h1);
        end
        wr(`REG_TXC0, 32'h0000_0080);
        settle;
      end
    end
    $display("test auto flush done");
    // preload entry presets the off bits once, software may rewrite them
    w = 32'($random(seed)) & 32'h0000_003f | 32'h1;
    wr(`REG_TXC0, w);
    rd(`REG_TXC0, exp_entry(w));
    chk("ready", preload_rdy_ff, 32'h0);
    chk("addr nack", addr_nack_ff, 32'h1);
    chk("preload", preload_mode_ff, 32'h1);
    wr(`REG_TXC0, 32'h0000_0021);
    rd(`REG_TXC0, 32'h0000_0021);
    u_tx_link_model.hit(1);
    settle;
    chk("lockout", lockout_ff, 32'h0);
    chk("nacked", u_tx_link_model.n_nacked, 32'h1);
    u_tx_link_model.hit(4);
    settle;
    chk("ready", preload_rdy_ff, 32'h1);
    u_tx_link_model.hit(2);
    settle;
    // six address matches of the auto-flush loop were acked before this one
    chk("acked", u_tx_link_model.n_acked, 32'h7);
    wr(`REG_TXC0, 32'h0);
    wr(`REG_TXC0, 32'h0000_0003);
    u_tx_link_model.hit(4);
    settle;
    chk("ready", preload_rdy_ff, 32'h0);
    wr(`REG_TXC1, 32'h1);
    settle;
    chk("ready", preload_rdy_ff, 32'h1);
    $display("test preload done");
    // interrupt: raise, mask, unmask, clear
    wr(`REG_TXC0, 32'h0);
    wr(`REG_EVT_MASK, 32'h1);
    u_tx_link_model.hit(3);
    settle;
    chk("irq", irq_ff, 32'h1);
    wr(`REG_EVT_MASK, 32'h0);
    settle;
    chk("irq", irq_ff, 32'h0);
    wr(`REG_EVT_MASK, 32'h1);
    settle;
    chk("irq", irq_ff, 32'h1);
    wr(`REG_EVT_STAT, 32'h1);
    settle;
    chk("irq", irq_ff, 32'h0);
    chk("lockout", lockout_ff, 32'h0);
    $display("test interrupt done");
    // clock enable low: a data write and a general call are both lost
    @(posedge clk);
    ce <= 1'b0;
    wr(`REG_TXDATA, 32'h0000_005a);
    u_tx_link_model.hit(3);
    @(posedge clk);
    ce <= 1'b1;
    settle;
    chk("level", tx_level, 32'h0);
    chk("lockout", lockout_ff, 32'h0);
    chk("irq", irq_ff, 32'h0);
    $display("test clock enable done");
    test_done;
  end
endmodule : i2c_tx_flush_ctrl_tb
